// *** src/beam_area_group_evaluator.sv ***
// Purpose: Block evaluation of beam areas, height teach and switching outputs
// Assumes: beam_interrupted is valid while cycle_done pulses
// Notes: Beam numbers on ports count from zero
`timescale 1ns/10ps
module beam_area_group_evaluator import area_eval_pkg::*; #(
    parameter int NUM_BEAMS = NUM_BEAMS_DEF,
    parameter int NUM_OUTS = OUT_COUNT_DEF,
    parameter int BW = $clog2(NUM_BEAMS)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Measurement
    input wire logic [NUM_BEAMS-1:0] beam_interrupted,
    input wire logic cycle_done,
    // Area configuration
    input wire area_mode_t area_mode,
    input wire logic [MAX_AREAS*BW-1:0] man_first,
    input wire logic [MAX_AREAS*BW-1:0] man_last,
    input wire logic [MAX_AREAS-1:0] man_or,
    input wire logic [CNT_W-1:0] man_count,
    input wire logic [CNT_W-1:0] split_count,
    input wire logic split_or,
    // Height teach
    input wire logic teach_start,
    input wire logic [1:0] teach_slot,
    input wire logic teach_from_panel,
    // Hold and outputs
    input wire logic [HOLD_W-1:0] hold_cycles,
    input wire logic [HEIGHT_AREAS*SEL_W-1:0] out_sel,
    input wire logic dark_switch,
    // Results
    output logic [WORD_W-1:0] area_state_upper_word,
    output logic [WORD_W-1:0] area_state_lower_word,
    output logic [HEIGHT_AREAS-1:0] height_state,
    output logic switch_output_one,
    output logic switch_output_two,
    output logic switch_output_three,
    output logic switch_output_four,
    output logic teach_done,
    output logic teach_fail
);
    localparam int SW = BW + CNT_W + 1;

    function automatic logic [BW-1:0] lowest_set(input logic [NUM_BEAMS-1:0] v);
        logic [BW-1:0] r;
        r = '0;
        for (int i = NUM_BEAMS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = BW'(i);
            end
        end
        return r;
    endfunction : lowest_set

    function automatic logic pick_bit(input logic [ALL_AREAS-1:0] v, input logic [SEL_W-1:0] s);
        return (int'(s) < ALL_AREAS) ? v[s] : 1'b0;
    endfunction : pick_bit

    logic [ALL_AREAS-1:0] grp_now;
    logic [ALL_AREAS-1:0] group_q;
    logic [ALL_AREAS-1:0] held_q;
    logic [ALL_AREAS-1:0] held_d;
    logic [HOLD_W-1:0] hold_cnt_q;
    logic [BW-1:0] h_first_q [HEIGHT_AREAS];
    logic [BW-1:0] h_last_q [HEIGHT_AREAS];
    logic [HEIGHT_AREAS-1:0] h_valid_q;
    logic [HEIGHT_AREAS-1:0] panel_map_q;
    logic teach_pend_q;
    logic pend_panel_q;
    logic [1:0] slot_q;
    logic [HEIGHT_AREAS-1:0] out_d;
    logic [HEIGHT_AREAS-1:0] out_q;
    logic teach_done_q;
    logic teach_fail_q;

    // ****************************************
    // Area configuration and evaluation
    // ****************************************
    wire [BW:0] split_size = (split_count == '0) ? '0 : (BW+1)'(NUM_BEAMS / int'(split_count));

    genvar i;
    generate
        for (i = 0; i < ALL_AREAS; i++) begin : g_area
            area_if #(.NB(NUM_BEAMS), .BW(BW)) ai ();
            assign ai.interrupted = beam_interrupted;
            if (i < MAX_AREAS) begin : g_user
                wire [SW-1:0] s_lo = SW'(i) * SW'(split_size);
                wire [SW-1:0] s_hi = s_lo + SW'(split_size) - SW'(1);
                wire auto_on = (CNT_W'(i) < split_count) && (split_size != '0);
                wire is_auto = area_mode == MODE_AUTOSPLIT;
                assign ai.first_beam = is_auto ? s_lo[BW-1:0] : man_first[i*BW +: BW];
                assign ai.last_beam = is_auto ? s_hi[BW-1:0] : man_last[i*BW +: BW];
                assign ai.enable = is_auto ? auto_on : (CNT_W'(i) < man_count);
                assign ai.use_or = is_auto ? split_or : man_or[i];
            end else begin : g_height
                assign ai.first_beam = h_first_q[i-MAX_AREAS];
                assign ai.last_beam = h_last_q[i-MAX_AREAS];
                assign ai.enable = h_valid_q[i-MAX_AREAS];
                assign ai.use_or = 1'b1;
            end
            area_group_eval #(.NB(NUM_BEAMS), .BW(BW)) u_eval (.a(ai));
            assign grp_now[i] = ai.group;
        end
    endgenerate

    // ****************************************
    // Height teach
    // ****************************************
    wire all_free = ~|beam_interrupted;
    wire bot_int = beam_interrupted[0];
    wire top_int = beam_interrupted[NUM_BEAMS-1];
    wire [BW-1:0] first_int = lowest_set(beam_interrupted);
    wire [NUM_BEAMS-1:0] rev_beams = {<<{beam_interrupted}};
    wire [BW-1:0] last_int = BW'(NUM_BEAMS - 1) - lowest_set(rev_beams);
    wire teach_ok = all_free || (bot_int != top_int);
    wire [BW-1:0] t_first = (all_free || top_int) ? '0 : last_int + BW'(1);
    wire [BW-1:0] t_last = (all_free || bot_int) ? BW'(NUM_BEAMS - 1) : first_int - BW'(1);
    wire commit = teach_pend_q && cycle_done;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            teach_pend_q <= 1'b0;
            pend_panel_q <= 1'b0;
            slot_q <= 2'h0;
        end else if (teach_start) begin
            teach_pend_q <= 1'b1;
            pend_panel_q <= teach_from_panel;
            slot_q <= teach_slot;
        end else if (cycle_done) begin
            teach_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            h_valid_q <= '0;
            panel_map_q <= '0;
            teach_done_q <= 1'b0;
            teach_fail_q <= 1'b0;
            for (int k = 0; k < HEIGHT_AREAS; k++) begin
                h_first_q[k] <= '0;
                h_last_q[k] <= '0;
            end
        end else begin
            teach_done_q <= commit && teach_ok;
            teach_fail_q <= commit && !teach_ok;
            if (commit && teach_ok) begin
                h_first_q[slot_q] <= t_first;
                h_last_q[slot_q] <= t_last;
                h_valid_q[slot_q] <= 1'b1;
                panel_map_q[slot_q] <= pend_panel_q;
            end
        end
    end

    // ****************************************
    // Hold and group registers
    // ****************************************
    wire hold_restart = (hold_cycles == '0) || (hold_cnt_q >= hold_cycles);
    assign held_d = hold_restart ? grp_now : (held_q | grp_now);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            group_q <= '0;
            held_q <= '0;
            hold_cnt_q <= HOLD_CNT_RST;
            out_q <= '0;
        end else if (cycle_done) begin
            group_q <= grp_now;
            held_q <= held_d;
            hold_cnt_q <= hold_restart ? HOLD_CNT_RST : hold_cnt_q + HOLD_W'(1);
            out_q <= out_d;
        end
    end

    // ****************************************
    // Switching outputs
    // ****************************************
    genvar q;
    generate
        for (q = 0; q < HEIGHT_AREAS; q++) begin : g_out
            wire src = panel_map_q[q] ? held_d[MAX_AREAS+q] : pick_bit(held_d, out_sel[q*SEL_W +: SEL_W]);
            assign out_d[q] = (q < NUM_OUTS) && (dark_switch ? src : !src);
        end
    endgenerate

    assign area_state_lower_word = held_q[WORD_W-1:0];
    assign area_state_upper_word = held_q[MAX_AREAS-1:WORD_W];
    assign height_state = held_q[ALL_AREAS-1:MAX_AREAS];
    assign switch_output_one = out_q[0];
    assign switch_output_two = out_q[1];
    assign switch_output_three = out_q[2];
    assign switch_output_four = out_q[3];
    assign teach_done = teach_done_q;
    assign teach_fail = teach_fail_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_request;
        teach_start && !cycle_done;
    endsequence
    sequence s_commit;
        teach_pend_q && cycle_done && !teach_start;
    endsequence

    a_group_on_cycle: assert property (cycle_done |=> group_q == $past(grp_now))
        else $error("group bits not taken at cycle end");
    a_group_stable: assert property (!cycle_done |=> $stable(group_q) && $stable(out_q))
        else $error("group bits changed between cycles");
    a_lower_word_map: assert property (cycle_done && hold_cycles == '0
        |=> area_state_lower_word == $past(grp_now[WORD_W-1:0]))
        else $error("lower word does not follow areas");
    a_upper_word_map: assert property (cycle_done && hold_cycles == '0
        |=> area_state_upper_word == $past(grp_now[MAX_AREAS-1:WORD_W]))
        else $error("upper word does not follow areas");
    a_hold_keeps_set: assert property (cycle_done && !hold_restart && held_q[0] |=> held_q[0])
        else $error("held area bit dropped inside hold period");
    a_autosplit_and: assert property (area_mode == MODE_AUTOSPLIT && split_count == 6'h01
        && !split_or |-> grp_now[0] == &beam_interrupted)
        else $error("single autosplit AND area wrong");
    a_light_switch: assert property (cycle_done && !panel_map_q[0] && out_sel[SEL_W-1:0] == '0
        |=> switch_output_one == ($past(dark_switch) ? held_q[0] : !held_q[0]))
        else $error("output polarity wrong");
    a_teach_latch: assert property (s_request |=> teach_pend_q)
        else $error("teach request not kept pending");
    a_teach_answer: assert property (s_commit |=> teach_done != teach_fail)
        else $error("teach gave no single answer");
    a_teach_all_free: assert property (s_commit and (all_free)
        |=> h_first_q[slot_q] == '0 && h_last_q[slot_q] == BW'(NUM_BEAMS - 1))
        else $error("free teach did not cover all beams");
    a_teach_mid_fail: assert property (s_commit and (!all_free && !bot_int && !top_int)
        |=> teach_fail && !teach_done)
        else $error("teach with no end beam interrupted accepted");
    a_panel_assign: assert property (s_commit and (pend_panel_q && teach_ok)
        |=> panel_map_q[slot_q])
        else $error("panel teach did not assign output");
endmodule : beam_area_group_evaluator

// *** shared/area_eval_pkg.sv ***
// Purpose: Shared constants and types for the beam area group evaluator
// Assumes: Beam states arrive once per measurement cycle on the device clock

package area_eval_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_BEAMS_DEF = 64;
    localparam int MAX_AREAS = 32;
    localparam int HEIGHT_AREAS = 4;
    localparam int ALL_AREAS = MAX_AREAS + HEIGHT_AREAS;
    localparam int WORD_W = 16;
    localparam int HOLD_W = 16;
    localparam int SEL_W = 6;
    localparam int CNT_W = 6;
    localparam int OUT_COUNT_DEF = 4;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [HOLD_W-1:0] HOLD_CNT_RST = 16'h0000;
    localparam logic OUT_RST = 1'h0;

    typedef enum logic {MODE_MANUAL, MODE_AUTOSPLIT} area_mode_t;
endpackage : area_eval_pkg

// *** shared/area_if.sv ***
// Purpose: Carries one area's configuration and its group bit
// Assumes: Beam index zero is the first beam
// Notes: Driven by the evaluator top, read by the area module
`timescale 1ns/10ps
interface area_if #(parameter int NB = 64, parameter int BW = 6);
    logic [NB-1:0] interrupted;
    logic [BW-1:0] first_beam;
    logic [BW-1:0] last_beam;
    logic enable;
    logic use_or;
    logic group;
    modport eval (input interrupted, first_beam, last_beam, enable, use_or, output group);
    modport ctrl (output interrupted, first_beam, last_beam, enable, use_or, input group);
endinterface : area_if

// *** src/area_group_eval.sv ***
// Purpose: Reduces the beams of one contiguous area to a group bit
// Assumes: first_beam not above last_beam for a non-empty area
// Notes: Purely combinational
`timescale 1ns/10ps
module area_group_eval #(
    parameter int NB = 64,
    parameter int BW = 6
) (
    area_if.eval a
);
    wire [NB-1:0] in_range;
    wire any_hit;
    wire all_hit;
    wire non_empty;

    // ****************************************
    // Beam range mask
    // ****************************************
    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_mask
            assign in_range[b] = (BW'(b) >= a.first_beam) && (BW'(b) <= a.last_beam);
        end
    endgenerate

    assign non_empty = a.first_beam <= a.last_beam;
    assign any_hit = |(a.interrupted & in_range);
    assign all_hit = &(a.interrupted | ~in_range);
    assign a.group = a.enable && non_empty && (a.use_or ? any_hit : all_hit);
endmodule : area_group_eval

// *** bench/plc_reader.sv ***
// Purpose: Controller model that reads the process data and outputs
// Assumes: Results settle one clock after the cycle_done pulse
// Notes: Takes one image per measurement cycle, read only
`timescale 1ns/10ps
module plc_reader import area_eval_pkg::*; (
    // Clock and cycle marker
    input wire logic clk,
    input wire logic cycle_done,
    // Process data
    input wire logic [WORD_W-1:0] lo_word,
    input wire logic [WORD_W-1:0] hi_word,
    input wire logic [3:0] outs,
    // Captured image
    output logic [2*WORD_W+3:0] image
);
    logic take_q = 1'b0;
    always_ff @(posedge clk) begin
        take_q <= cycle_done;
        if (take_q) begin
            image <= {outs, hi_word, lo_word};
        end
    end
endmodule : plc_reader

// *** bench/beam_area_group_evaluator_tb.sv ***
// Purpose: Self-checking bench for the beam area group evaluator
// Assumes: Inputs change on the falling clock edge
// Notes: Table rows first, then hand-written cases
`timescale 1ns/10ps
module beam_area_group_evaluator_tb import area_eval_pkg::*; ;
    typedef struct packed {
        logic [5:0] f;
        logic [5:0] l;
        logic o;
        logic [63:0] b;
        logic e;
    } row_t;
    localparam row_t ROWS [9] = '{
        '{6'h00, 6'h3F, 1'h0, 64'hFFFF_FFFF_FFFF_FFFF, 1'h1},
        '{6'h00, 6'h3F, 1'h0, 64'hFFFF_FFFF_FFFF_FFFE, 1'h0},
        '{6'h00, 6'h3F, 1'h1, 64'h20, 1'h1},
        '{6'h00, 6'h3F, 1'h1, 64'h0, 1'h0},
        '{6'h07, 6'h07, 1'h1, 64'h80, 1'h1},
        '{6'h07, 6'h07, 1'h1, 64'h40, 1'h0},
        '{6'h0A, 6'h0C, 1'h0, 64'h1C00, 1'h1},
        '{6'h0A, 6'h0C, 1'h0, 64'h3800, 1'h0},
        '{6'h0A, 6'h0C, 1'h1, 64'h2200, 1'h0}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cd = 1'b0;
    logic [63:0] beams = 64'h0;
    area_mode_t mode = MODE_MANUAL;
    logic [191:0] mf = 192'h0;
    logic [191:0] ml = 192'h0;
    logic [31:0] mor = 32'h0;
    logic [5:0] mcnt = 6'h0;
    logic [5:0] scnt = 6'h0;
    logic sor = 1'b0;
    logic tst = 1'b0;
    logic [1:0] tslot = 2'h0;
    logic tpanel = 1'b0;
    logic [15:0] hold = 16'h0;
    logic [23:0] osel = 24'h0;
    logic dark = 1'b0;
    logic [15:0] hi_w;
    logic [15:0] lo_w;
    logic [3:0] hgt;
    logic [3:0] outs;
    logic t_done;
    logic t_fail;
    logic [35:0] image;
    logic [2:0] n;
    logic [1:0] tres;
    int err_count = 0;
    int check_count = 0;

    always #4 clk = ~clk;

    beam_area_group_evaluator i_dut (
        .clk(clk), .rstn(rstn), .beam_interrupted(beams), .cycle_done(cd),
        .area_mode(mode), .man_first(mf), .man_last(ml), .man_or(mor),
        .man_count(mcnt), .split_count(scnt), .split_or(sor),
        .teach_start(tst), .teach_slot(tslot), .teach_from_panel(tpanel),
        .hold_cycles(hold), .out_sel(osel), .dark_switch(dark),
        .area_state_upper_word(hi_w), .area_state_lower_word(lo_w),
        .height_state(hgt), .switch_output_one(outs[0]),
        .switch_output_two(outs[1]), .switch_output_three(outs[2]),
        .switch_output_four(outs[3]), .teach_done(t_done), .teach_fail(t_fail));

    plc_reader i_plc (
        .clk(clk), .cycle_done(cd), .lo_word(lo_w), .hi_word(hi_w),
        .outs(outs), .image(image));

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic do_reset;
        rstn = 1'b0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        chk({hi_w, lo_w, hgt}, 36'h0);
        chk({outs, t_done, t_fail}, 36'h0);
    endtask : do_reset

    task automatic meas(input logic [63:0] b);
        beams = b;
        cd = 1'b1;
        @(negedge clk);
        cd = 1'b0;
        @(negedge clk);
    endtask : meas

    task automatic teach(input logic [1:0] s, input logic p, input logic [63:0] b);
        tst = 1'b1;
        tslot = s;
        tpanel = p;
        @(negedge clk);
        tst = 1'b0;
        @(negedge clk);
        beams = b;
        cd = 1'b1;
        @(negedge clk);
        cd = 1'b0;
        tres = {t_done, t_fail};
        @(negedge clk);
    endtask : teach

    initial begin
        #400000;
        err_count++;
        finish_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        @(negedge clk);
        do_reset();
        mcnt = 6'h01;
        for (int i = 0; i < 9; i++) begin
            mf[5:0] = ROWS[i].f;
            ml[5:0] = ROWS[i].l;
            mor[0] = ROWS[i].o;
            meas(ROWS[i].b);
            chk(image, {{4{~ROWS[i].e}}, 31'h0, ROWS[i].e});
        end
        mcnt = 6'h20;
        mor = 32'h5555_5555;
        for (int i = 0; i < 32; i++) begin
            mf[i*6 +: 6] = 6'(i);
            ml[i*6 +: 6] = 6'(i + 1);
        end
        meas(64'h0000_0001_8000_001C);
        chk(image[31:0], 32'hC000_001C);
        mode = MODE_AUTOSPLIT;
        scnt = 6'h20;
        meas(64'hC000_0000_0000_0013);
        chk(image[31:0], 32'h8000_0001);
        scnt = 6'h10;
        sor = 1'b1;
        meas(64'h8000_0000_0000_0000);
        chk(image[31:0], 32'h0000_8000);
        scnt = 6'h03;
        meas(64'h8000_0000_0000_0000);
        chk(image[31:0], 32'h0);
        mode = MODE_MANUAL;
        mcnt = 6'h01;
        ml[5:0] = 6'h3F;
        dark = 1'b1;
        meas(64'h1);
        chk(image[35:32], 4'hF);
        meas(64'h0);
        chk(image[35:32], 4'h0);
        dark = 1'b0;
        hold = 16'h0002;
        repeat (3) meas(64'h0);
        meas(64'h1);
        chk(image[0], 1'h1);
        n = 3'h0;
        repeat (4) begin
            meas(64'h0);
            n = n + 3'(image[0]);
        end
        chk({n != 3'h0 && n <= 3'h2, image[0]}, 2'h2);
        hold = 16'h0;
        mcnt = 6'h00;
        teach(2'h0, 1'b1, 64'h3FF);
        chk(tres, 2'h2);
        meas(64'h10_0000);
        chk({hgt, outs}, {4'h1, 4'hE});
        meas(64'h20);
        chk({hgt, outs}, {4'h0, 4'hF});
        teach(2'h1, 1'b0, 64'h0);
        meas(64'h8000_0000_0000_0000);
        chk({hgt, outs}, {4'h3, 4'hE});
        teach(2'h2, 1'b0, 64'hFFFC_0000_0000_0000);
        meas(64'h0002_0000_0000_0000);
        chk(hgt, 4'h7);
        teach(2'h3, 1'b0, 64'h4000_0000);
        chk(tres, 2'h1);
        teach(2'h3, 1'b0, 64'h8000_0000_0000_0001);
        chk(tres, 2'h1);
        meas(64'hFFFF_FFFF_FFFF_FFFF);
        chk(hgt, 4'h7);
        do_reset();
        meas(64'hFFFF_FFFF_FFFF_FFFF);
        chk({hgt, outs}, {4'h0, 4'hF});
        finish_test();
    end
endmodule : beam_area_group_evaluator_tb
